// ===== text_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - keep up to 250 characters in order
// - delete removes newest, echoes it back
// - control-E empties the whole memory
// - marker stored but never printed
// - marker read during print halts print
// - control-C resumes after the halting marker
// - control-P prints from first character
// - print until end or next marker
// - bell when entering into full memory
// - bell on print of empty memory
// - bell on delete of empty memory
// - serial bits on one output, one input
// - bit rate divided from system clock
// - all logic on one system clock
// - external reset restores initial state
module text_ctrl
   import text_ctrl_pkg::*;
#(
   parameter int unsigned BIT_CYC = BIT_CYC_DEF
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // serial link
   input wire logic rxd,
   output line_out_t line_out,
   // status
   output logic [PTR_W-1:0] fill_count,
   output logic printing
);
   localparam logic [CNT_W-1:0] BIT_N = CNT_W'(BIT_CYC);
   localparam logic [CNT_W-1:0] HALF_N = CNT_W'(BIT_CYC / 2);
   localparam logic [3:0] FRAME_N = 4'(BITS_PER_FRAME);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, // waiting for a character
      S_RD = 3'b001, // memory read issued
      S_CHK = 3'b010, // read data available
      S_SEND = 3'b011, // transmitter busy
      S_HALT = 3'b100 // stopped at marker
   } ctl_t;
   // receiver sync and state
   logic rx_s1_r, rx_s2_r; // two-stage synchroniser
   logic rx_busy_r, rx_busy_nxt;
   logic [CNT_W-1:0] rx_cnt_r, rx_cnt_nxt;
   logic [3:0] rx_bit_r, rx_bit_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt;
   rx_char_t rx_ev;
   // transmitter state
   logic tx_busy_r, tx_busy_nxt;
   logic [CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
   logic [3:0] tx_bit_r, tx_bit_nxt;
   logic [9:0] tx_sh_r, tx_sh_nxt;
   logic tx_go; // load request from control
   logic [7:0] tx_char;
   // control state
   ctl_t st_r, st_nxt;
   logic [PTR_W-1:0] cnt_r, cnt_nxt; // stored characters
   logic [PTR_W-1:0] rp_r, rp_nxt; // print position
   logic echo_r, echo_nxt; // read is for delete echo
   logic we;
   logic [PTR_W-1:0] raddr;
   logic [7:0] rdata;
   // pin synchroniser
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= rxd;
         rx_s2_r <= rx_s1_r;
      end
   end
   // receiver next state, sample mid-bit
   always_comb begin
      rx_busy_nxt = rx_busy_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_bit_nxt = rx_bit_r;
      rx_sh_nxt = rx_sh_r;
      rx_ev = '0;
      if (!rx_busy_r) begin
         if (!rx_s2_r) begin // start edge
            rx_busy_nxt = 1'b1;
            rx_cnt_nxt = HALF_N;
            rx_bit_nxt = '0;
         end
      end else if (rx_cnt_r != '0) begin
         rx_cnt_nxt = rx_cnt_r - 1'b1;
      end else begin
         rx_cnt_nxt = BIT_N - 1'b1;
         rx_bit_nxt = rx_bit_r + 1'b1;
         if (rx_bit_r == 4'h0) begin
            // false start if line back at mark
            if (rx_s2_r) begin
               rx_busy_nxt = 1'b0;
            end
         end else if (rx_bit_r < 4'h9) begin
            rx_sh_nxt = {rx_s2_r, rx_sh_r[7:1]}; // lsb first
         end else begin
            rx_busy_nxt = 1'b0;
            rx_ev.valid = rx_s2_r; // framing error drops char
            rx_ev.data = rx_sh_r;
         end
      end
   end
   // receiver registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rx_busy_r <= 1'b0;
         rx_cnt_r <= '0;
         rx_bit_r <= '0;
         rx_sh_r <= '0;
      end else begin
         rx_busy_r <= rx_busy_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_sh_r <= rx_sh_nxt;
      end
   end
   // transmitter next state
   always_comb begin
      tx_busy_nxt = tx_busy_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_bit_nxt = tx_bit_r;
      tx_sh_nxt = tx_sh_r;
      if (!tx_busy_r) begin
         if (tx_go) begin
            // stop, data, start; shifted lsb first
            tx_sh_nxt = {1'b1, tx_char, 1'b0};
            tx_busy_nxt = 1'b1;
            tx_cnt_nxt = BIT_N - 1'b1;
            tx_bit_nxt = '0;
         end
      end else if (tx_cnt_r != '0) begin
         tx_cnt_nxt = tx_cnt_r - 1'b1;
      end else begin
         tx_cnt_nxt = BIT_N - 1'b1;
         tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
         tx_bit_nxt = tx_bit_r + 1'b1;
         if (tx_bit_r == FRAME_N - 1'b1) begin
            tx_busy_nxt = 1'b0;
         end
      end
   end
   // transmitter registers; idle at mark
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tx_busy_r <= 1'b0;
         tx_cnt_r <= '0;
         tx_bit_r <= '0;
         tx_sh_r <= 10'h3ff;
      end else begin
         tx_busy_r <= tx_busy_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_sh_r <= tx_sh_nxt;
      end
   end
   assign line_out.txd = tx_sh_r[0]; // single output line
   // control next state
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      rp_nxt = rp_r;
      echo_nxt = echo_r;
      we = 1'b0;
      raddr = rp_r;
      tx_go = 1'b0;
      tx_char = CH_BELL;
      unique case (st_r)
         S_IDLE, S_HALT: begin
            // characters arriving while halted are typed insertions
            if (rx_ev.valid) begin
               unique case (rx_ev.data)
                  // erase all; software reset does the same
                  CH_CTRL_E, CH_CTRL_R: begin
                     cnt_nxt = '0;
                     rp_nxt = '0;
                     st_nxt = S_IDLE;
                  end
                  CH_DEL: begin
                     if (cnt_r == '0) begin
                        tx_go = 1'b1; // bell
                        st_nxt = S_SEND;
                     end else begin
                        // read newest then drop it
                        cnt_nxt = cnt_r - 1'b1;
                        rp_nxt = cnt_r - 1'b1;
                        echo_nxt = 1'b1;
                        st_nxt = S_RD;
                     end
                  end
                  CH_CTRL_P: begin
                     if (cnt_r == '0) begin
                        tx_go = 1'b1;
                        st_nxt = S_SEND;
                     end else begin
                        rp_nxt = '0;
                        echo_nxt = 1'b0;
                        st_nxt = S_RD;
                     end
                  end
                  CH_CTRL_C: begin
                     if (st_r == S_HALT) begin
                        // rp already past the marker
                        echo_nxt = 1'b0;
                        st_nxt = S_RD;
                     end
                  end
                  default: begin
                     if (cnt_r == PTR_MAX) begin
                        tx_go = 1'b1;
                        st_nxt = S_SEND;
                     end else begin
                        // markers stored like any char
                        we = 1'b1;
                        cnt_nxt = cnt_r + 1'b1;
                     end
                  end
               endcase
            end
         end
         S_RD: begin
            st_nxt = S_CHK; // address presented this cycle
         end
         S_CHK: begin
            if (!echo_r && rdata == CH_CTRL_B) begin
               rp_nxt = rp_r + 1'b1; // halt, not printed
               st_nxt = S_HALT;
            end else begin
               // echo or printed character
               tx_char = rdata;
               tx_go = 1'b1;
               echo_nxt = 1'b0;
               rp_nxt = echo_r ? PTR_RST : rp_r + 1'b1;
               st_nxt = S_SEND;
            end
         end
         S_SEND: begin
            if (!tx_busy_r && !tx_go) begin
               // continue print until end of text
               st_nxt = (printing && rp_r < cnt_r) ? S_RD : S_IDLE;
            end
         end
         default: begin
            st_nxt = S_IDLE;
         end
      endcase
   end

   // printing flag, remembered across the send wait
   logic print_r, print_nxt;
   always_comb begin
      print_nxt = print_r;
      if (st_nxt == S_HALT) begin
         print_nxt = 1'b0; // marker ends the run
      end else if (st_r == S_CHK) begin
         print_nxt = !echo_r; // delete echo is no print-out
      end else if (st_r == S_SEND && st_nxt == S_IDLE) begin
         print_nxt = 1'b0;
      end
   end
   // control registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= S_IDLE;
         cnt_r <= PTR_RST;
         rp_r <= PTR_RST;
         echo_r <= 1'b0;
         print_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         rp_r <= rp_nxt;
         echo_r <= echo_nxt;
         print_r <= print_nxt;
      end
   end
   assign printing = print_r;
   assign fill_count = cnt_r;
   // character store
   text_mem #(
      .DEPTH(BUF_DEPTH)
   ) u_mem (
      .clk_sys(clk_sys),
      .we(we),
      .waddr(cnt_r),
      .wdata(rx_ev.data),
      .raddr(raddr),
      .rdata(rdata)
   );
endmodule

// ===== text_ctrl_pkg.sv
package text_ctrl_pkg;
   // buffer capacity in characters
   localparam int unsigned BUF_DEPTH = 250;
   localparam int unsigned PTR_W = 8;
   localparam int unsigned CHAR_W = 8;
   localparam logic [PTR_W-1:0] PTR_MAX = 8'hfa;
   localparam logic [PTR_W-1:0] PTR_RST = 8'h00;
   // control character codes
   localparam logic [7:0] CH_DEL = 8'h7f;
   localparam logic [7:0] CH_CTRL_E = 8'h05;
   localparam logic [7:0] CH_CTRL_B = 8'h02;
   localparam logic [7:0] CH_CTRL_C = 8'h03;
   localparam logic [7:0] CH_CTRL_P = 8'h10;
   localparam logic [7:0] CH_CTRL_R = 8'h12;
   localparam logic [7:0] CH_BELL = 8'h07;
   // clock and baud timing
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned BAUD_DEF = 300;
   localparam int unsigned BIT_CYC_DEF = CLK_HZ / BAUD_DEF;
   localparam int unsigned CNT_W = 20;
   localparam int unsigned BITS_PER_FRAME = 10;
   // serial output pin txd as one carrier
   typedef struct packed {
      logic txd;
   } line_out_t;
   // one received character event
   typedef struct packed {
      logic valid;
      logic [CHAR_W-1:0] data;
   } rx_char_t;
endpackage

// ===== text_ctrl_sva.sv
`timescale 1ns/1ps
// port checker for the text controller
module text_ctrl_sva
   import text_ctrl_pkg::*;
#(
   parameter int unsigned BIT_CYC = BIT_CYC_DEF
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // serial link
   input wire logic rxd,
   input wire line_out_t line_out,
   // status
   input wire logic [PTR_W-1:0] fill_count,
   input wire logic printing
);
   logic txd_r; // txd one cycle ago
   logic [CNT_W-1:0] run_r; // cycles txd held its level
   logic [CNT_W-1:0] run_nxt;
   logic [CNT_W-1:0] low_r; // cycles txd held low
   logic [CNT_W-1:0] low_nxt;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // run length counters
   always_comb begin
      run_nxt = (line_out.txd != txd_r) ? '0 : run_r + 1'b1;
      low_nxt = line_out.txd ? '0 : low_r + 1'b1;
   end
   // register counters
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         txd_r <= 1'b1;
         run_r <= '0;
         low_r <= '0;
      end else begin
         txd_r <= line_out.txd;
         run_r <= run_nxt;
         low_r <= low_nxt;
      end
   end
   property p_cap;
      fill_count <= PTR_MAX;
   endproperty
   a_cap: assert property (p_cap)
      else $error("fill above capacity");
   property p_step;
      $changed(fill_count) |-> fill_count == PTR_RST ||
         fill_count == $past(fill_count) + 8'h01 ||
         fill_count == $past(fill_count) - 8'h01;
   endproperty
   a_step: assert property (p_step)
      else $error("fill jumped");
   property p_take;
      $changed(fill_count) |-> rxd && $past(rxd, 3);
   endproperty
   a_take: assert property (p_take)
      else $error("fill moved off stop bit");
   property p_hold;
      printing && $past(printing) |-> $stable(fill_count);
   endproperty
   a_hold: assert property (p_hold)
      else $error("memory moved in print");
   property p_start;
      $rose(printing) |-> ##[0:4] !line_out.txd;
   endproperty
   a_start: assert property (p_start)
      else $error("print start late");
   property p_nonempty;
      printing |-> fill_count != PTR_RST;
   endproperty
   a_nonempty: assert property (p_nonempty)
      else $error("empty print");
   property p_low;
      low_r <= 9 * BIT_CYC;
   endproperty
   a_low: assert property (p_low)
      else $error("txd low too long");
   property p_bit_len;
      $changed(line_out.txd) |-> run_r >= BIT_CYC - 1;
   endproperty
   a_bit_len: assert property (p_bit_len)
      else $error("short bit");
   // main scenarios reached
   c_print: cover property ($rose(printing));
   c_full: cover property (fill_count == PTR_MAX);
   c_clear: cover property ($changed(fill_count) && fill_count == PTR_RST);
endmodule
bind text_ctrl text_ctrl_sva #(.BIT_CYC(BIT_CYC)) u_sva (.clk_sys(clk_sys),
   .arst_n(arst_n), .rxd(rxd), .line_out(line_out),
   .fill_count(fill_count), .printing(printing));

// ===== text_ctrl_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the text controller
module text_ctrl_tb_top;
   import text_ctrl_pkg::*;
   localparam int unsigned BC = 16; // shortened bit time
   logic clk_sys = 1'b0; // system clock
   logic arst_n = 1'b0; // async reset
   logic rxd; // serial into controller
   line_out_t line_out; // serial out
   logic [PTR_W-1:0] fill_count; // stored count
   logic printing; // print-out running
   int err_total = 0; // mismatches
   int checked = 0; // comparisons
   int cyc = 0; // cycle count for the ceiling
   int seed = 32'he3b9483c; // fixed seed
   logic [7:0] mem_q[$]; // expected stored text
   always #4 clk_sys = ~clk_sys;
   text_ctrl #(.BIT_CYC(BC)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
      .rxd(rxd), .line_out(line_out), .fill_count(fill_count),
      .printing(printing));
   text_term #(.BIT_CYC(BC)) u_term (.clk_sys(clk_sys),
      .txd(line_out.txd), .rxd(rxd));
   // compare one byte value
   task automatic cmp_val(input string n, input logic [7:0] e,
      input logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // next character from the controller, bounded wait
   task automatic get_char(input logic [7:0] e);
      int n;
      n = 0;
      while (u_term.got_q.size() == 0 && n < 40 * BC) begin
         @(posedge clk_sys);
         n++;
      end
      cmp_val("tx char", e,
         (u_term.got_q.size() != 0) ? u_term.got_q.pop_front() : 8'hxx);
   endtask
   // wait until link and print-out are quiet
   task automatic quiet();
      int n;
      n = 0;
      while (n < 12 * BC) begin
         @(posedge clk_sys);
         n = (line_out.txd === 1'b1 && printing === 1'b0) ? n + 1 : 0;
      end
   endtask
   // type a character that is stored silently
   task automatic put(input logic [7:0] ch);
      u_term.send(ch);
      mem_q.push_back(ch);
      cmp_val("fill", 8'(mem_q.size()), fill_count);
   endtask
   // random printable character
   function automatic logic [7:0] rnd_char(input int r);
      return 8'h20 + 8'($unsigned(r) % 95);
   endfunction
   // verdict and end of run
   task automatic results();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // cycle ceiling against hangs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         results();
      end
   end
   // main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      u_term.send(CH_CTRL_P);
      get_char(CH_BELL);
      u_term.send(CH_DEL);
      get_char(CH_BELL);
      quiet();
      $display("test empty done");
      for (int i = 0; i < 6; i++)
         put(i == 3 ? CH_CTRL_B : rnd_char($random(seed)));
      u_term.send(CH_CTRL_P);
      for (int i = 0; i < 3; i++) get_char(mem_q[i]);
      cmp_val("printing", 8'h01, 8'(printing));
      quiet();
      cmp_val("extra", 8'h00, 8'(u_term.got_q.size()));
      put(rnd_char($random(seed))); // operator insertion
      u_term.send(CH_CTRL_C);
      for (int i = 4; i < 7; i++) get_char(mem_q[i]);
      quiet();
      cmp_val("stop errors", 8'h00, 8'(u_term.bad_stop));
      repeat (2) begin
         u_term.send(CH_DEL);
         get_char(mem_q.pop_back());
         quiet();
      end
      cmp_val("fill", 8'(mem_q.size()), fill_count);
      $display("test print done");
      u_term.send(CH_CTRL_E);
      mem_q.delete();
      cmp_val("fill", 8'h00, fill_count);
      for (int i = 0; i < BUF_DEPTH; i++) put(rnd_char($random(seed)));
      u_term.send(8'h41);
      get_char(CH_BELL);
      quiet();
      cmp_val("fill", PTR_MAX, fill_count);
      u_term.send(CH_DEL);
      get_char(mem_q.pop_back());
      quiet();
      u_term.send(CH_CTRL_R);
      mem_q.delete();
      cmp_val("fill", 8'h00, fill_count);
      put(8'h42);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      cmp_val("fill", 8'h00, fill_count);
      cmp_val("txd", 8'h01, 8'(line_out.txd));
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      u_term.send(CH_CTRL_P);
      get_char(CH_BELL);
      $display("test full and reset done");
      results();
   end
endmodule

// ===== text_mem.sv
`timescale 1ns/1ps
// character memory, registered read data
module text_mem
   import text_ctrl_pkg::*;
#(
   parameter int unsigned DEPTH = BUF_DEPTH
) (
   // clock
   input wire logic clk_sys,
   // write port
   input wire logic we,
   input wire logic [PTR_W-1:0] waddr,
   input wire logic [CHAR_W-1:0] wdata,
   // read port
   input wire logic [PTR_W-1:0] raddr,
   output logic [CHAR_W-1:0] rdata
);
   logic [CHAR_W-1:0] mem [DEPTH];
   // write and registered read
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// ===== text_term.sv
`timescale 1ns/1ps
// terminal at the far end of the serial link
module text_term
   import text_ctrl_pkg::*;
#(
   parameter int unsigned BIT_CYC = 16
) (
   // clock
   input wire logic clk_sys,
   // serial link
   input wire logic txd,
   output logic rxd
);
   logic [7:0] got_q[$]; // characters heard
   logic [7:0] sh; // receive shift register
   int bad_stop = 0; // frames with a low stop bit
   initial rxd = 1'b1; // idle at mark
   // send one frame, then one idle bit of spacing
   task automatic send(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys);
         rxd <= f[i]; // start, lsb first, stop
         repeat (BIT_CYC - 1) @(posedge clk_sys);
      end
      repeat (BIT_CYC) @(posedge clk_sys);
   endtask
   // receive frames, sampling at mid-bit
   always begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clk_sys);
         sh = {txd, sh[7:1]}; // lsb first
      end
      repeat (BIT_CYC) @(posedge clk_sys);
      if (txd !== 1'b1) bad_stop++;
      got_q.push_back(sh);
   end
endmodule
